// File: verilog/urfc_top.sv
// receive FIFO control of one endpoint, APB register slave
// assumes APB master, USB interface pushing bytes with valid/ready
`timescale 1ns/1ps

// Contract
// - with the wait-state bit set every FIFO data read gets one wait.
// - with the bit clear, FIFO data reads answer with zero waits.
// - a flush leaves the wait-state bit as it was.
// - writing one to read-done clears the flag of the set just read.
// - hardware clears read-done after that occupancy flag clears.
// - read-done releases nothing while either overwrite bit is set.
// - the isochronous bit sets only the USB side to iso mode (usbIsoMode); the FIFO logic ignores it.
// - a flush keeps the iso bit; only a firmware write or a reset clears it.
// - two test bits advance the marker and reverse the pointer.
// - flush empties the FIFO, resets flags, then clears itself.
module urfc_top
   import urfc_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // usb interface side
   input  wire logic        usbValid,
   input  wire logic [7:0]  usbData,
   output logic             usbReady,
   input  wire logic        usbPacketAck,
   input  wire logic        usbPacketNak,
   output logic             usbIsoMode,
   // cpu read path
   output logic             rdStall
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rstSync1_ff;
   logic rstn_ff;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstSync1_ff <= 1'b0;
         rstn_ff     <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstn_ff     <= rstSync1_ff;
      end
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   urfc_ctrl_t    ctrl_ff;
   logic [1:0]    ovw_ff;
   logic [1:0]    occ_ff;
   logic          setWr_ff;
   logic          setRd_ff;
   logic          rel_ff;
   logic          ackPend_ff;
   logic          nakPend_ff;
   logic [AW:0]   wp_ff;
   logic [AW:0]   wm_ff;
   logic [AW:0]   rp_ff;
   logic [7:0]    mem_ff [DEPTH];
   urfc_rd_t      rdSt_ff;
   logic [31:0]   rdData_ff;
   logic          err_ff;
   logic          rdHas_ff;
   urfc_byte_t    bufIn;
   urfc_byte_t    bufOut;
   logic          bufValid;
   logic          bufReady;
   logic          setup;
   logic          access;
   logic          xferDone;
   logic          isDataRd;
   logic          ctrlWr;
   logic          ovwWr;
   logic          mapped;
   logic          fifoEmpty;
   logic          fifoFull;
   logic          memWr;
   logic          pop;
   logic          commit;
   logic          rewind;
   logic          releaseReq;
   logic [7:0]    ctrlRd;
   logic [2:0]    flagRd;

   // ----------------------------------------------------------------
   // input buffer
   // ----------------------------------------------------------------
   assign bufIn.data = usbData;

   urfc_buf2 #(
      .WIDTH ($bits(urfc_byte_t))
   ) u_buf (
      .clk_sys  (clk_sys),
      .rstn     (rstn_ff),
      .inValid  (usbValid),
      .inReady  (usbReady),
      .inData   (bufIn),
      .outValid (bufValid),
      .outReady (bufReady),
      .outData  (bufOut)
   );

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   assign isDataRd = ~pwrite & (paddr == URFC_DATA_OFFS);
   assign mapped   = (paddr == URFC_CTRL_OFFS) | (paddr == URFC_OVW_OFFS)
                   | (paddr == URFC_FLAG_OFFS) | (paddr == URFC_DATA_OFFS);
   assign pready   = access & ((rdSt_ff == URFC_DONE) | ~isDataRd
                   | ~ctrl_ff.waitState);
   assign rdStall  = access & isDataRd & ctrl_ff.waitState
                   & (rdSt_ff != URFC_DONE);
   assign xferDone = access & pready;
   assign ctrlWr   = xferDone & pwrite & (paddr == URFC_CTRL_OFFS);
   assign ovwWr    = xferDone & pwrite & (paddr == URFC_OVW_OFFS);
   assign prdata   = rdData_ff;
   assign pslverr  = access & err_ff;

   // wait-state sequencer of a data read
   always_ff @(posedge clk_sys or negedge rstn_ff) begin
      if (!rstn_ff) begin
         rdSt_ff <= URFC_IDLE;
      end else begin
         case (rdSt_ff)
            URFC_IDLE: begin
               if (access && isDataRd && ctrl_ff.waitState)
                  rdSt_ff <= URFC_DONE;
            end
            URFC_DONE: rdSt_ff <= URFC_IDLE;
            default:   rdSt_ff <= URFC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status and read data
   // ----------------------------------------------------------------
   assign fifoEmpty = (rp_ff == wm_ff);
   assign fifoFull  = (wp_ff[AW] != rp_ff[AW])
                    & (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   assign ctrlRd    = {ctrl_ff.flush, 1'b0, ctrl_ff.waitState,
                       ctrl_ff.readDone, ctrl_ff.isoSel, 1'b0,
                       ctrl_ff.advMarker, ctrl_ff.revPointer};
   assign flagRd    = {fifoEmpty, occ_ff};

   always_ff @(posedge clk_sys or negedge rstn_ff) begin
      if (!rstn_ff) begin
         rdData_ff <= 32'h0000_0000;
         err_ff    <= 1'b0;
         rdHas_ff  <= 1'b0;
      end else if (setup) begin
         err_ff   <= ~mapped;
         // pop only a byte that was handed out at setup
         rdHas_ff <= ~fifoEmpty;
         case (paddr)
            URFC_CTRL_OFFS: rdData_ff <= {24'h00_0000, ctrlRd};
            URFC_OVW_OFFS:  rdData_ff <= {30'h0000_0000, ovw_ff};
            URFC_FLAG_OFFS: rdData_ff <= {29'h0000_0000, flagRd};
            URFC_DATA_OFFS: rdData_ff <= fifoEmpty ? 32'h0000_0000
                                       : {24'h00_0000,
                                          mem_ff[rp_ff[AW-1:0]]};
            default:        rdData_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   assign releaseReq = ctrl_ff.readDone & ~rel_ff
                     & ~ovw_ff[URFC_BIT_STOVR]
                     & ~ovw_ff[URFC_BIT_EDOVR];
   assign usbIsoMode = ctrl_ff.isoSel;

   always_ff @(posedge clk_sys or negedge rstn_ff) begin
      if (!rstn_ff) begin
         ctrl_ff <= '0;
         ovw_ff  <= URFC_OVW_RESET;
         rel_ff  <= 1'b0;
      end else begin
         rel_ff <= releaseReq;
         // hardware clears come first so a new set wins
         if (ctrl_ff.flush) ctrl_ff.flush <= 1'b0;
         if (rel_ff) ctrl_ff.readDone <= 1'b0;
         ctrl_ff.advMarker  <= 1'b0;
         ctrl_ff.revPointer <= 1'b0;
         if (ctrlWr) begin
            // flush leaves these two alone
            ctrl_ff.waitState <= pwdata[URFC_BIT_WS];
            ctrl_ff.isoSel    <= pwdata[URFC_BIT_ISO];
            if (pwdata[URFC_BIT_FLUSH]) ctrl_ff.flush <= 1'b1;
            if (pwdata[URFC_BIT_DONE]) ctrl_ff.readDone <= 1'b1;
            if (pwdata[URFC_BIT_ADVM]) ctrl_ff.advMarker <= 1'b1;
            if (pwdata[URFC_BIT_REVP]) ctrl_ff.revPointer <= 1'b1;
         end
         if (ovwWr) begin
            ovw_ff <= pwdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // fifo pointers and data sets
   // ----------------------------------------------------------------
   assign bufReady = ~fifoFull & ~ctrl_ff.flush;
   assign memWr    = bufValid & bufReady;
   assign pop      = xferDone & isDataRd & rdHas_ff;
   assign commit   = ackPend_ff & ~bufValid;
   assign rewind   = nakPend_ff & ~bufValid;

   always_ff @(posedge clk_sys) begin
      if (memWr) mem_ff[wp_ff[AW-1:0]] <= bufOut.data;
   end

   always_ff @(posedge clk_sys or negedge rstn_ff) begin
      if (!rstn_ff) begin
         wp_ff      <= '0;
         wm_ff      <= '0;
         rp_ff      <= '0;
         ackPend_ff <= 1'b0;
         nakPend_ff <= 1'b0;
      end else if (ctrl_ff.flush) begin
         wp_ff      <= '0;
         wm_ff      <= '0;
         rp_ff      <= '0;
         ackPend_ff <= 1'b0;
         nakPend_ff <= 1'b0;
      end else begin
         if (usbPacketAck) ackPend_ff <= 1'b1;
         else if (commit) ackPend_ff <= 1'b0;
         if (usbPacketNak) nakPend_ff <= 1'b1;
         else if (rewind) nakPend_ff <= 1'b0;
         if (pop) rp_ff <= rp_ff + 1'b1;
         if (ctrl_ff.revPointer || rewind) begin
            wp_ff <= wm_ff;
         end else if (memWr) begin
            wp_ff <= wp_ff + 1'b1;
         end
         if (ctrl_ff.advMarker || commit) wm_ff <= wp_ff;
      end
   end

   // occupancy flags; a commit wins over a release of the same set
   always_ff @(posedge clk_sys or negedge rstn_ff) begin
      if (!rstn_ff) begin
         occ_ff   <= 2'b00;
         setWr_ff <= 1'b0;
         setRd_ff <= 1'b0;
      end else if (ctrl_ff.flush) begin
         occ_ff   <= 2'b00;
         setWr_ff <= 1'b0;
         setRd_ff <= 1'b0;
      end else begin
         if (releaseReq) begin
            occ_ff[setRd_ff] <= 1'b0;
            setRd_ff         <= ~setRd_ff;
         end
         if (commit) begin
            occ_ff[setWr_ff] <= 1'b1;
            setWr_ff         <= ~setWr_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_ws_stall_once: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (setup && isDataRd && ctrl_ff.waitState)
         |=> !pready && rdStall ##1 pready && !rdStall
   ) else $error("wait-state read not stretched by one cycle");

   a_nows_ready_now: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (setup && isDataRd && !ctrl_ff.waitState) |=> pready
   ) else $error("zero-wait read did not answer at once");

   a_stall_one_cycle: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      $rose(rdStall) |=> !rdStall
   ) else $error("stall lasted more than one cycle");

   a_flush_keeps_bits: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (ctrl_ff.flush && !ctrlWr)
         |=> $stable(ctrl_ff.waitState) && $stable(ctrl_ff.isoSel)
   ) else $error("flush disturbed wait or iso bit");

   a_flush_empties: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (ctrl_ff.flush && !ctrlWr)
         |=> fifoEmpty && occ_ff == 2'b00 && !ctrl_ff.flush
   ) else $error("flush did not empty the fifo");

   a_done_releases: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (releaseReq && !commit && !ctrl_ff.flush)
         |=> !occ_ff[$past(setRd_ff)] && (setRd_ff != $past(setRd_ff))
   ) else $error("read-done did not clear the set flag");

   a_done_selfclear: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (releaseReq ##1 !ctrlWr) |=> !ctrl_ff.readDone
   ) else $error("read-done not cleared by hardware");

   a_ovw_blocks_done: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (ctrl_ff.readDone && ovw_ff != 2'b00 && !commit && !ctrl_ff.flush)
         |=> occ_ff == $past(occ_ff)
   ) else $error("release happened while overwrite set");

   a_iso_follows_wr: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      ctrlWr |=> usbIsoMode == $past(pwdata[URFC_BIT_ISO])
   ) else $error("iso mode does not follow firmware write");

   a_adv_marker: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (ctrl_ff.advMarker && !ctrl_ff.flush) |=> wm_ff == $past(wp_ff)
   ) else $error("test advance did not move the marker");

   a_rev_pointer: assert property (
      @(posedge clk_sys) disable iff (!rstn_ff)
      (ctrl_ff.revPointer && !ctrl_ff.flush) |=> wp_ff == $past(wm_ff)
   ) else $error("test reverse did not move the pointer");

endmodule

// File: verilog/urfc_pkg.sv
// shared constants and types of the receive FIFO control block
// assumes an APB slave with 32-bit data and one aligned word per register
package urfc_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] URFC_CTRL_OFFS = 8'h00;
   localparam logic [7:0] URFC_OVW_OFFS  = 8'h04;
   localparam logic [7:0] URFC_FLAG_OFFS = 8'h08;
   localparam logic [7:0] URFC_DATA_OFFS = 8'h0C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int URFC_BIT_FLUSH = 7;
   localparam int URFC_BIT_WS    = 5;
   localparam int URFC_BIT_DONE  = 4;
   localparam int URFC_BIT_ISO   = 3;
   localparam int URFC_BIT_ADVM  = 1;
   localparam int URFC_BIT_REVP  = 0;
   localparam int URFC_BIT_STOVR = 0;
   localparam int URFC_BIT_EDOVR = 1;
   localparam int URFC_BIT_OCC0  = 0;
   localparam int URFC_BIT_OCC1  = 1;
   localparam int URFC_BIT_EMPTY = 2;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] URFC_CTRL_RESET = 8'h00;
   localparam logic [1:0] URFC_OVW_RESET  = 2'h0;
   localparam int         URFC_WAIT_CYC   = 1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic flush;
      logic waitState;
      logic readDone;
      logic isoSel;
      logic advMarker;
      logic revPointer;
   } urfc_ctrl_t;

   typedef struct packed {
      logic [7:0] data;
   } urfc_byte_t;

   typedef enum logic [1:0] {
      URFC_IDLE  = 2'b00,
      URFC_WAIT  = 2'b01,
      URFC_DONE  = 2'b10
   } urfc_rd_t;

endpackage

// File: verilog/urfc_buf2.sv
// two-entry valid/ready buffer in the receive data path
// assumes one clock and a synchronous active-low reset copy
`timescale 1ns/1ps
module urfc_buf2
   import urfc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] slot_ff [2];
   logic             head_ff;
   logic             tail_ff;
   logic [1:0]       count_ff;
   logic             push;
   logic             pop;

   assign inReady  = (count_ff != 2'h2);
   assign outValid = (count_ff != 2'h0);
   assign outData  = slot_ff[head_ff];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         head_ff  <= 1'b0;
         tail_ff  <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         if (push) tail_ff <= ~tail_ff;
         if (pop) head_ff <= ~head_ff;
         if (push && !pop) count_ff <= count_ff + 2'h1;
         else if (pop && !push) count_ff <= count_ff - 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) slot_ff[tail_ff] <= inData;
   end

endmodule

// File: tb/urfc_usb_model.sv
// usb function interface model: pushes bytes, then ends the packet
// assumes one caller at a time and a clk_sys shared with the block
`timescale 1ns/1ps
module urfc_usb_model (
   // clock
   input  wire logic       clk_sys,
   // byte stream
   input  wire logic       usbReady,
   output logic            usbValid,
   output logic [7:0]      usbData,
   // packet end
   output logic            usbPacketAck,
   output logic            usbPacketNak
);
   logic sendOk;

   initial begin
      usbValid     = 1'b0;
      usbData      = 8'h00;
      usbPacketAck = 1'b0;
      usbPacketNak = 1'b0;
      sendOk       = 1'b1;
   end

   // -------------------------------------------------------------
   // n bytes counting up from base, gap idle cycles between them
   // -------------------------------------------------------------
   task automatic send(input int n, input logic [7:0] base,
                       input logic ack, input int gap);
      int k;
      @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         usbValid <= 1'b1;
         usbData  <= base + 8'(i);
         k = 0;
         @(posedge clk_sys);
         while (usbReady !== 1'b1 && k < 400) begin
            k++;
            @(posedge clk_sys);
         end
         if (k == 400) begin
            sendOk = 1'b0;
         end
         if (i == n - 1 || gap > 0) begin
            usbValid <= 1'b0;
            usbData  <= ~(base + 8'(i));
         end
         repeat (gap) @(posedge clk_sys);
      end
      if (ack) begin
         usbPacketAck <= 1'b1;
      end else begin
         usbPacketNak <= 1'b1;
      end
      @(posedge clk_sys);
      usbPacketAck <= 1'b0;
      usbPacketNak <= 1'b0;
   endtask
endmodule

// File: tb/test_usb_receive_fifo_control.sv
// self-checking bench of the receive fifo control block
// assumes urfc_pkg, urfc_top and the usb model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
   errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_usb_receive_fifo_control
   import urfc_pkg::*;
;
   localparam int DEPTH = 32;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
      logic       err;
   } urfc_tb_row_t;

   logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
   logic        usbValid, usbReady, usbPacketAck, usbPacketNak;
   logic        usbIsoMode, rdStall, err;
   logic [7:0]  paddr, usbData;
   logic [31:0] pwdata, prdata, rd;
   int          errors, cmp_count, cyc, stalls;
   urfc_tb_row_t rows [5] = '{
      '{URFC_CTRL_OFFS, 8'h28, 8'h28, 1'b0},
      '{URFC_CTRL_OFFS, 8'h44, 8'h00, 1'b0},
      '{URFC_OVW_OFFS,  8'h03, 8'h03, 1'b0},
      '{URFC_OVW_OFFS,  8'h00, 8'h00, 1'b0},
      '{8'h10,          8'h5A, 8'h00, 1'b1}};

   urfc_top #(.DEPTH(DEPTH), .AW(5)) DUT (
      .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .usbValid(usbValid), .usbData(usbData), .usbReady(usbReady),
      .usbPacketAck(usbPacketAck), .usbPacketNak(usbPacketNak),
      .usbIsoMode(usbIsoMode), .rdStall(rdStall));

   urfc_usb_model usb (
      .clk_sys(clk_sys), .usbReady(usbReady), .usbValid(usbValid),
      .usbData(usbData), .usbPacketAck(usbPacketAck),
      .usbPacketNak(usbPacketNak));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // -------------------------------------------------------------
   // bus tasks
   // -------------------------------------------------------------
   task automatic test_done();
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= {24'h000000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      stalls = 0;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (rdStall === 1'b1) stalls++;
         if (pready === 1'b1) break;
      end
      cyc = n;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         errors++;
         test_done();
      end
      @(posedge clk_sys);
   endtask

   task automatic wait_flags(input logic [7:0] e);
      for (int n = 0; n < 50; n++) begin
         apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
         if (rd[7:0] === e) break;
      end
      `CHK(rd[7:0], e)
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      errors = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      apb(URFC_CTRL_OFFS, 1'b0, 8'h00);
      `CHK({usbIsoMode, rd[7:0]}, {1'b0, URFC_CTRL_RESET})
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h04)
      foreach (rows[i]) begin
         apb(rows[i].addr, 1'b1, rows[i].wdata);
         apb(rows[i].addr, 1'b0, 8'h00);
         `CHK({err, rd[7:0]}, {rows[i].err, rows[i].rexp})
      end
      // one slow packet, read with zero then one wait state
      usb.send(3, 8'hA0, 1'b1, 1);
      wait_flags(8'h01);
      for (int i = 0; i < 3; i++) begin
         apb(URFC_CTRL_OFFS, 1'b1, (i == 0) ? 8'h00 : 8'h20);
         apb(URFC_DATA_OFFS, 1'b0, 8'h00);
         `CHK(cyc[1:0], 2'(i != 0))
         `CHK(stalls[1:0], 2'(i != 0))
         `CHK(rd[7:0], 8'hA0 + 8'(i))
      end
      // release held off by either overwrite bit
      apb(URFC_OVW_OFFS, 1'b1, 8'h01);
      apb(URFC_CTRL_OFFS, 1'b1, 8'h30);
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h05)
      apb(URFC_OVW_OFFS, 1'b1, 8'h02);
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h05)
      apb(URFC_CTRL_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h30)
      apb(URFC_OVW_OFFS, 1'b1, 8'h00);
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h04)
      apb(URFC_CTRL_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h20)
      // two packets back to back, release one set only
      usb.send(2, 8'hB0, 1'b1, 0);
      usb.send(1, 8'hC0, 1'b1, 2);
      wait_flags(8'h03);
      for (int i = 0; i < 2; i++) begin
         apb(URFC_DATA_OFFS, 1'b0, 8'h00);
         `CHK(rd[7:0], 8'hB0 + 8'(i))
      end
      apb(URFC_CTRL_OFFS, 1'b1, 8'h30);
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h01)
      apb(URFC_DATA_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'hC0)
      apb(URFC_CTRL_OFFS, 1'b1, 8'h30);
      wait_flags(8'h04);
      // iso on, fill until refused, flush, packet refused
      apb(URFC_CTRL_OFFS, 1'b1, 8'h28);
      `CHK(usbIsoMode, 1'b1)
      fork
         usb.send(DEPTH + 3, 8'h00, 1'b0, 0);
      join_none
      repeat (DEPTH + 20) @(posedge clk_sys);
      `CHK(usbReady, 1'b0)
      apb(URFC_CTRL_OFFS, 1'b1, 8'hA8);
      apb(URFC_CTRL_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h28)
      repeat (20) @(posedge clk_sys);
      `CHK(usb.sendOk, 1'b1)
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h04)
      apb(URFC_DATA_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h00)
      apb(URFC_CTRL_OFFS, 1'b1, 8'h00);
      `CHK(usbIsoMode, 1'b0)
      // test bits move the marker and pointer, then self clear
      fork
         usb.send(1, 8'hD0, 1'b0, 40);
      join_none
      repeat (5) @(posedge clk_sys);
      apb(URFC_CTRL_OFFS, 1'b1, 8'h03);
      apb(URFC_FLAG_OFFS, 1'b0, 8'h00);
      `CHK(rd[2], 1'b0)
      apb(URFC_CTRL_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h00)
      apb(URFC_DATA_OFFS, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'hD0)
      apb(URFC_CTRL_OFFS, 1'b1, 8'h80);
      wait_flags(8'h04);
      test_done();
   end
endmodule
